// >>> hdl/piaar_map.vh
/*
 * Constants for the identifier and advertisement register block:
 * register addresses, field positions, reset values, strap decode
 * and management frame lengths.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PIAAR_MAP_VH
`define PIAAR_MAP_VH

// register addresses on the management bus
`define PIAAR_REG_IDENT_LOW    5'h03
`define PIAAR_REG_ADVERT       5'h04

// identifier low field positions
`define PIAAR_ID_ORG_HI        15
`define PIAAR_ID_ORG_LO        10
`define PIAAR_ID_MODEL_HI      9
`define PIAAR_ID_MODEL_LO      4
`define PIAAR_ID_REV_HI        3
`define PIAAR_ID_REV_LO        0

// advertisement field positions
`define PIAAR_ADV_NEXT_PAGE    15
`define PIAAR_ADV_RSVD_14      14
`define PIAAR_ADV_FAR_FAULT    13
`define PIAAR_ADV_PAUSE        10
`define PIAAR_ADV_FOUR_PAIR    9
`define PIAAR_ADV_ABIL_HI      8
`define PIAAR_ADV_ABIL_LO      5
`define PIAAR_ADV_SEL_HI       4
`define PIAAR_ADV_SEL_LO       0

// writable bits: 15, 13, 10, 8..0
`define PIAAR_ADV_WR_MASK      16'hA5FF
// reset value before the straps are taken in
`define PIAAR_ADV_RESET        16'h0001
`define PIAAR_SEL_CSMA         5'h01

// ability bits 8..5 chosen by the two straps {b, a}
`define PIAAR_STRAP_00         4'hF
`define PIAAR_STRAP_01         4'h3
`define PIAAR_STRAP_10         4'hC
`define PIAAR_STRAP_11         4'h5
// edges after reset release before the synchronised straps are valid
`define PIAAR_STRAP_SETTLE     2'h2

// management frame
`define PIAAR_PREAMBLE_BITS    6'h20
`define PIAAR_HDR_LAST         5'h0B
`define PIAAR_DATA_BITS        5'h10
`define PIAAR_DATA_LAST        5'h0F
`define PIAAR_SKIP_LAST        5'h11
`define PIAAR_OP_READ          2'h2
`define PIAAR_OP_WRITE         2'h1

`endif

// >>> hdl/piaar_sync.v
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to i_clk; the output is
 * safe to feed logic on i_clk.
 */
`timescale 1ns/100ps
module piaar_sync #(
    parameter W = 4
) (
    // clock and reset
    input  wire         i_clk,
    input  wire         i_rst_n,
    // pins
    input  wire [W-1:0] i_async,
    // synchronised copy
    output reg  [W-1:0] o_sync
);

    reg [W-1:0] meta;

    // meta is read only by the second stage
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

// >>> hdl/piaar_mgmt_regs.v
/*
 * Identifier-low and auto-negotiation advertisement registers behind
 * the serial management interface (clock pin plus two-way data pin).
 * Assumes mdc and mdio come from the station manager, asynchronous to
 * i_clk and far slower than it; the negotiation engine reads
 * o_advert_word.
 */
// Summary of operation
// - identifier bits 15:10 hold fixed organisation code bits 19..24
// - identifier bits 9:4 hold fixed model number, msb at bit 9
// - identifier bits 3:0 hold fixed revision, msb at bit 3
// - advertisement register is the ability word sent to the partner
// - bit 15 next page request, read-write, resets to 0
// - bit 14 reserved, writes ignored, reads 0
// - bit 13 far fault advertisement, read-write, resets to 0
// - bits 12:11 reserved, read 0; software writes zeros
// - bit 10 pause flow control advertisement, read-write, resets to 0
// - bit 9 four-pair ability, read-only zero
// - bits 8:5 reset to 0, loaded from two straps on the third clock edge after reset release, then software-writable
// - bit 8 advertises 100 Mb/s full duplex
// - bit 7 advertises 100 Mb/s half duplex
// - bit 6 advertises 10 Mb/s full duplex, bit 5 10 Mb/s
// - bits 4:0 selector, read-write, resets to 00001
`timescale 1ns/100ps
`include "piaar_map.vh"
module piaar_mgmt_regs #(
    parameter [4:0] PHY_ADDR   = 5'h01,
    // identity values below are arbitrary
    parameter [5:0] ORG_CODE   = 6'h2A,
    parameter [5:0] MODEL_NUM  = 6'h15,
    parameter [3:0] REVISION   = 4'h3
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // serial management pins
    input  wire        i_mdc,
    input  wire        i_mdio,
    output reg         o_mdio,
    output reg         o_mdio_oe,
    // negotiation straps
    input  wire        i_negotiation_strap_a,
    input  wire        i_negotiation_strap_b,
    // ability word to the negotiation engine
    output reg  [15:0] o_advert_word
);

    localparam [7:0] S_PRE   = 8'b0000_0001;
    localparam [7:0] S_ST    = 8'b0000_0010;
    localparam [7:0] S_HDR   = 8'b0000_0100;
    localparam [7:0] S_TA_RD = 8'b0000_1000;
    localparam [7:0] S_RD    = 8'b0001_0000;
    localparam [7:0] S_TA_WR = 8'b0010_0000;
    localparam [7:0] S_WR    = 8'b0100_0000;
    localparam [7:0] S_SKIP  = 8'b1000_0000;

    wire [3:0]  sync;
    wire        mdc_s;
    wire        mdio_s;
    wire [1:0]  strap_s;
    reg         mdc_q;
    wire        mdc_rise;
    reg  [7:0]  state;
    reg  [5:0]  pre_cnt;
    reg  [4:0]  bit_cnt;
    reg  [15:0] shift;
    reg  [15:0] rd_word;
    reg  [4:0]  wr_addr;
    reg         wr_stb;
    reg  [15:0] wr_data;
    reg  [1:0]  strap_cnt;
    reg         strap_done;
    wire [11:0] hdr;
    wire [15:0] ident_low;

    // pins pass two flops before any logic
    piaar_sync #(
        .W (4)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_mdc, i_mdio, i_negotiation_strap_b, i_negotiation_strap_a}),
        .o_sync  (sync)
    );

    assign mdc_s    = sync[3];
    assign mdio_s   = sync[2];
    assign strap_s  = sync[1:0];
    assign mdc_rise = mdc_s & ~mdc_q;
    assign hdr      = {shift[10:0], mdio_s};

    // fixed identifier word, no storage so writes cannot reach it
    assign ident_low = {ORG_CODE, MODEL_NUM, REVISION};

    function [3:0] strap_abilities;
        input [1:0] straps;
        begin
            case (straps)
                2'b00: strap_abilities = `PIAAR_STRAP_00;
                2'b01: strap_abilities = `PIAAR_STRAP_01;
                2'b10: strap_abilities = `PIAAR_STRAP_10;
                default: strap_abilities = `PIAAR_STRAP_11;
            endcase
        end
    endfunction

    function [15:0] read_word;
        input [4:0]  addr;
        input [15:0] advert;
        input [15:0] ident;
        begin
            if (addr == `PIAAR_REG_IDENT_LOW) begin
                read_word = ident;
            end else if (addr == `PIAAR_REG_ADVERT) begin
                read_word = advert;
            end else begin
                read_word = 16'h0000;
            end
        end
    endfunction

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mdc_q <= 1'b0;
        end else begin
            mdc_q <= mdc_s;
        end
    end

    // straps caught after release, once the synchroniser holds real levels
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            if (strap_cnt == `PIAAR_STRAP_SETTLE) begin
                strap_done <= 1'b1;
            end else begin
                strap_cnt <= strap_cnt + 2'h1;
            end
        end
    end

    // advertisement register; reserved and four-pair bits never stored
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_advert_word <= `PIAAR_ADV_RESET;
        end else if (!strap_done && strap_cnt == `PIAAR_STRAP_SETTLE) begin
            o_advert_word[`PIAAR_ADV_ABIL_HI:`PIAAR_ADV_ABIL_LO] <=
                strap_abilities(strap_s);
        end else if (wr_stb && wr_addr == `PIAAR_REG_ADVERT) begin
            // masked write keeps bits 14, 12, 11 and 9 at zero
            o_advert_word <= (o_advert_word & ~`PIAAR_ADV_WR_MASK)
                           | (wr_data & `PIAAR_ADV_WR_MASK);
        end
    end

    // frame engine, one step per rising mdc
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= S_PRE;
            pre_cnt   <= 6'h00;
            bit_cnt   <= 5'h00;
            shift     <= 16'h0000;
            rd_word   <= 16'h0000;
            wr_addr   <= 5'h00;
            wr_stb    <= 1'b0;
            wr_data   <= 16'h0000;
            o_mdio    <= 1'b0;
            o_mdio_oe <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    S_PRE: begin
                        if (mdio_s) begin
                            if (pre_cnt != `PIAAR_PREAMBLE_BITS) begin
                                pre_cnt <= pre_cnt + 6'h01;
                            end
                        end else if (pre_cnt == `PIAAR_PREAMBLE_BITS) begin
                            state <= S_ST;
                        end else begin
                            pre_cnt <= 6'h00;
                        end
                    end
                    S_ST: begin
                        pre_cnt <= 6'h00;
                        bit_cnt <= 5'h00;
                        if (mdio_s) begin
                            state <= S_HDR;
                        end else begin
                            state <= S_PRE;
                        end
                    end
                    S_HDR: begin
                        shift   <= {shift[14:0], mdio_s};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `PIAAR_HDR_LAST) begin
                            bit_cnt <= 5'h00;
                            wr_addr <= hdr[4:0];
                            if (hdr[9:5] != PHY_ADDR) begin
                                state <= S_SKIP;
                            end else if (hdr[11:10] == `PIAAR_OP_READ) begin
                                rd_word <= read_word(hdr[4:0], o_advert_word, ident_low);
                                state   <= S_TA_RD;
                            end else if (hdr[11:10] == `PIAAR_OP_WRITE) begin
                                state <= S_TA_WR;
                            end else begin
                                state <= S_SKIP;
                            end
                        end
                    end
                    S_TA_RD: begin
                        // second turnaround bit driven low
                        o_mdio_oe <= 1'b1;
                        o_mdio    <= 1'b0;
                        state     <= S_RD;
                    end
                    S_RD: begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `PIAAR_DATA_BITS) begin
                            o_mdio_oe <= 1'b0;
                            o_mdio    <= 1'b0;
                            bit_cnt   <= 5'h00;
                            state     <= S_PRE;
                        end else begin
                            o_mdio  <= rd_word[15];
                            rd_word <= {rd_word[14:0], 1'b0};
                        end
                    end
                    S_TA_WR: begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt != 5'h00) begin
                            bit_cnt <= 5'h00;
                            state   <= S_WR;
                        end
                    end
                    S_WR: begin
                        shift   <= {shift[14:0], mdio_s};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `PIAAR_DATA_LAST) begin
                            // identifier address ignored by the register process
                            wr_stb  <= 1'b1;
                            wr_data <= {shift[14:0], mdio_s};
                            bit_cnt <= 5'h00;
                            state   <= S_PRE;
                        end
                    end
                    default: begin
                        // frame for another port or with another opcode: sit out turnaround and data
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `PIAAR_SKIP_LAST) begin
                            bit_cnt <= 5'h00;
                            state   <= S_PRE;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// >>> tb/piaar_mgmt_regs_props.sv
/* port checker for the identifier and advertisement registers.
   assumes a bind onto piaar_mgmt_regs and one clock domain. */
`timescale 1ns/100ps
`include "piaar_map.vh"
module piaar_mgmt_regs_props (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    // management pins
    input wire logic        i_mdc,
    input wire logic        i_mdio,
    input wire logic        o_mdio,
    input wire logic        o_mdio_oe,
    // straps and ability word
    input wire logic        i_negotiation_strap_a,
    input wire logic        i_negotiation_strap_b,
    input wire logic [15:0] o_advert_word
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic       mdc_q;
    logic [3:0] since_rise;
    logic [3:0] since_rst;
    logic [3:0] strap_dec;
    assign strap_dec = i_negotiation_strap_b ?
        (i_negotiation_strap_a ? `PIAAR_STRAP_11 : `PIAAR_STRAP_10) :
        (i_negotiation_strap_a ? `PIAAR_STRAP_01 : `PIAAR_STRAP_00);
    // saturating counters bound how late a change may follow its cause
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mdc_q <= 1'b0;
            since_rise <= 4'hF;
            since_rst <= 4'h0;
        end else begin
            mdc_q <= i_mdc;
            since_rise <= (i_mdc && !mdc_q) ? 4'h0 :
                          ((since_rise == 4'hF) ? since_rise : since_rise + 4'h1);
            since_rst <= (since_rst == 4'hF) ? since_rst : since_rst + 4'h1;
        end
    end
    rsvd_bit14_a: assert property (o_advert_word[14] == 1'b0)
        else $error("advert bit 14 not zero");
    rsvd_bits12_a: assert property (o_advert_word[12:11] == 2'h0)
        else $error("advert bits 12:11 not zero");
    four_pair_a: assert property (o_advert_word[9] == 1'b0)
        else $error("four-pair ability not zero");
    reset_value_a: assert property ($rose(i_rst_n) |->
        (o_advert_word & 16'hA41F) == 16'h0001) else $error("advert reset value wrong");
    strap_load_a: assert property ($rose(i_rst_n) |->
        ##4 o_advert_word[8:5] == strap_dec) else $error("strap abilities wrong");
    change_cause_a: assert property (!$stable(o_advert_word) |->
        since_rise <= 4'h8 || since_rst <= 4'h6) else $error("advert changed unprompted");
    read_start_a: assert property ($rose(o_mdio_oe) |->
        since_rise <= 4'h6 && !o_mdio) else $error("read drive start wrong");
    read_hold_a: assert property ($rose(o_mdio_oe) |-> o_mdio_oe[*8])
        else $error("read drive dropped early");
endmodule
bind piaar_mgmt_regs piaar_mgmt_regs_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_mdc(i_mdc), .i_mdio(i_mdio), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
    .i_negotiation_strap_a(i_negotiation_strap_a),
    .i_negotiation_strap_b(i_negotiation_strap_b), .o_advert_word(o_advert_word));

// >>> tb/piaar_station.sv
/* station manager model: makes management frames on clock and data pins.
   assumes the bench resolves the data wire with a pull-up when idle. */
`timescale 1ns/100ps
`include "piaar_map.vh"
module piaar_station (
    // clock
    input  wire logic i_clk,
    // management pins
    input  wire logic i_mdio,
    output logic      o_mdc,
    output logic      o_mdio,
    output logic      o_mdio_oe
);
    localparam int HALF = 6; // above the four-cycle minimum per phase
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b0;
        o_mdio_oe = 1'b0;
    end
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, 2'b01, op, phy, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(negedge i_clk);
            o_mdc <= 1'b0;
            o_mdio_oe <= (op == `PIAAR_OP_WRITE) || (i > 17);
            o_mdio <= f[i];
            repeat (HALF) @(negedge i_clk);
            if (i < 16) rd = {rd[14:0], i_mdio};
            o_mdc <= 1'b1;
            repeat (HALF - 1) @(negedge i_clk);
        end
        @(negedge i_clk);
        o_mdc <= 1'b0; // clock stands still between frames
        o_mdio_oe <= 1'b0;
        repeat (2 * HALF) @(negedge i_clk);
    endtask
endmodule

// >>> tb/piaar_mgmt_regs_tb_top.sv
/* self-checking bench for the identifier and advertisement registers.
   assumes the station model and checker are compiled before it. */
`timescale 1ns/100ps
`include "piaar_map.vh"
module piaar_mgmt_regs_tb_top;
    localparam logic [15:0] ID = {6'h2A, 6'h15, 4'h3};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  strap = 2'h0;
    logic        sm_mdc;
    logic        sm_mdio;
    logic        sm_oe;
    logic        dut_mdio;
    logic        dut_oe;
    logic [15:0] adv;
    logic [15:0] rd;
    logic [3:0]  smap [4] = '{`PIAAR_STRAP_00, `PIAAR_STRAP_01, `PIAAR_STRAP_10, `PIAAR_STRAP_11};
    int          err_count = 0;
    int          checked = 0;
    wire         mdio_w = dut_oe ? dut_mdio : (sm_oe ? sm_mdio : 1'b1); // pull-up
    piaar_mgmt_regs #(.PHY_ADDR(5'h01), .ORG_CODE(6'h2A), .MODEL_NUM(6'h15),
        .REVISION(4'h3)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_mdc(sm_mdc),
        .i_mdio(mdio_w), .o_mdio(dut_mdio), .o_mdio_oe(dut_oe),
        .i_negotiation_strap_a(strap[0]), .i_negotiation_strap_b(strap[1]),
        .o_advert_word(adv));
    piaar_station sm (.i_clk(clk), .i_mdio(mdio_w), .o_mdc(sm_mdc), .o_mdio(sm_mdio),
        .o_mdio_oe(sm_oe));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
        sm.xfer(`PIAAR_OP_READ, 5'h01, ra, 16'h0000, rd);
        chk(rd, exp);
    endtask
    task automatic wr_reg(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
        sm.xfer(`PIAAR_OP_WRITE, phy, ra, wd, rd);
    endtask
    task automatic do_reset(input logic [1:0] s);
        @(negedge clk);
        rst_n = 1'b0;
        strap = s;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task automatic summarize;
        if (err_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        do_reset(2'h0);
        rd_reg(`PIAAR_REG_IDENT_LOW, ID);
        wr_reg(5'h01, `PIAAR_REG_IDENT_LOW, 16'h0000);
        rd_reg(`PIAAR_REG_IDENT_LOW, ID);
        wr_reg(5'h01, `PIAAR_REG_ADVERT, 16'hFFFF);
        rd_reg(`PIAAR_REG_ADVERT, 16'hA5FF);
        chk(adv, 16'hA5FF);
        wr_reg(5'h01, `PIAAR_REG_ADVERT, 16'h8421);
        rd_reg(`PIAAR_REG_ADVERT, 16'h8421);
        wr_reg(5'h02, `PIAAR_REG_ADVERT, 16'h0000);
        rd_reg(`PIAAR_REG_ADVERT, 16'h8421);
        rd_reg(5'h05, 16'h0000);
        wr_reg(5'h01, `PIAAR_REG_ADVERT, 16'h0000);
        rd_reg(`PIAAR_REG_ADVERT, 16'h0000);
        // every strap code, each after a fresh reset mid-run
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            rd_reg(`PIAAR_REG_ADVERT, {7'h00, smap[s], 5'h01});
        end
        summarize();
    end
    // about 12600 cycles expected; generous margin
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
endmodule
